// ==== rtl/port_pkg.sv ====
// constants for the port latch and pull-up control block
package port_pkg;
    localparam logic [7:0] PORT0_ADDR   = 8'h80;
    localparam logic [7:0] PORT1_ADDR   = 8'h90;
    localparam logic [7:0] PORT2_ADDR   = 8'ha0;
    localparam logic [7:0] PULL1_ADDR   = 8'hb3;
    localparam logic [7:0] PULL2_ADDR   = 8'hb4;
    localparam logic [7:0] LATCH_RESET  = 8'hff;
    localparam logic [7:0] PULL_RESET   = 8'h00;
    localparam logic [7:0] UNMAPPED_RD  = 8'h00;
    localparam int         P2_PINS      = 3;
    localparam int         SDL_BIT      = 3;
    localparam int         RST_PULL_BIT = 5;
endpackage

// ==== rtl/pad_if.sv ====
// carrier between the register core and one port's pad logic
`timescale 1ns/1ps
interface pad_if #(parameter int N = 8);
    logic [N-1:0] latch;
    logic [N-1:0] pull_dis;
    logic [N-1:0] alt_en;
    logic [N-1:0] alt_out;
    logic [N-1:0] level;
    modport core (output latch, output pull_dis, output alt_en,
                  output alt_out, input level);
    modport pad  (input latch, input pull_dis, input alt_en,
                  input alt_out, output level);
endinterface

// ==== rtl/pad_drive.sv ====
// pad drive and input synchroniser for one port
`timescale 1ns/1ps
module pad_drive #(parameter int N = 8)
(
    input  wire logic         core_clk,
    input  wire logic         rstn,
    pad_if.pad                ctl,
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] pin_out,
    output logic      [N-1:0] pin_oe_n,
    output logic      [N-1:0] pin_pullup_en
);
    logic [N-1:0] meta_q;
    logic [N-1:0] level_q;
    logic [N-1:0] high_d;

    // pins idle high through the pull-up, so sync resets to ones
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q  <= '1;
            level_q <= '1;
        end
        else
        begin
            meta_q  <= pin_in;
            level_q <= meta_q;
        end
    end

    assign ctl.level = level_q;

    // alternate function passes only while the latch holds one
    assign high_d = ctl.latch & (~ctl.alt_en | ctl.alt_out);

    // only ever pull low; a high is left to the pull-up or outside
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_out       <= '1;
            pin_oe_n      <= '1;
            pin_pullup_en <= '1;
        end
        else
        begin
            pin_out       <= high_d;
            pin_oe_n      <= high_d;
            pin_pullup_en <= ~ctl.pull_dis;
        end
    end
endmodule

// ==== rtl/port_latches_and_pullup_control.sv ====
// port latches, pin reads and pull-up control on the sfr bus
`timescale 1ns/1ps
module port_latches_and_pullup_control
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic       read_pin_sel,
    output logic      [7:0] sfr_rdata,
    output logic            sfr_hit,
    input  wire logic [7:0] bit_addr,
    input  wire logic       bit_wdata,
    input  wire logic       bit_wr,
    input  wire logic       bit_rd,
    output logic            bit_rdata,
    input  wire logic [7:0] port_zero_pin_in,
    output logic      [7:0] port_zero_pin_out,
    output logic      [7:0] port_zero_oe_n,
    output logic      [7:0] port_zero_pullup_en,
    input  wire logic [7:0] port_zero_alt_en,
    input  wire logic [7:0] port_zero_alt_out,
    input  wire logic [7:0] port_one_pin_in,
    output logic      [7:0] port_one_pin_out,
    output logic      [7:0] port_one_oe_n,
    output logic      [7:0] port_one_pullup_en,
    input  wire logic [7:0] port_one_alt_en,
    input  wire logic [7:0] port_one_alt_out,
    input  wire logic [2:0] port_two_pin_in,
    output logic      [2:0] port_two_pin_out,
    output logic      [2:0] port_two_oe_n,
    output logic      [2:0] port_two_pullup_en,
    input  wire logic [2:0] port_two_alt_en,
    input  wire logic [2:0] port_two_alt_out,
    output logic            serial_download_pin,
    output logic            reset_pin_pullup_en
);
    logic [7:0] port_zero_latch_q;
    logic [7:0] port_one_latch_q;
    logic [7:0] port_two_latch_q;
    logic [7:0] port_one_pullup_disable_q;
    logic [7:0] port_two_pullup_disable_q;
    logic [7:0] p0_view;
    logic [7:0] p1_view;
    logic [7:0] p2_view;
    logic [7:0] rd_d;
    logic       bit_d;

    pad_if #(.N(8))                p0if ();
    pad_if #(.N(8))                p1if ();
    pad_if #(.N(port_pkg::P2_PINS)) p2if ();

    // bit address falls inside the byte at base
    function automatic logic bit_sel(input logic [7:0] base,
                                     input logic [7:0] ba);
        return ba[7:3] == base[7:3];
    endfunction

    // a byte write wins over a bit write landing in the same cycle
    function automatic logic [7:0] latch_next(input logic [7:0] old,
                                              input logic [7:0] base);
        logic [7:0] r;
        r = old;
        if (sfr_wr && sfr_addr == base)
            r = sfr_wdata;
        else if (bit_wr && bit_sel(base, bit_addr))
            r[bit_addr[2:0]] = bit_wdata;
        return r;
    endfunction

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            port_zero_latch_q <= port_pkg::LATCH_RESET;
            port_one_latch_q  <= port_pkg::LATCH_RESET;
            port_two_latch_q  <= port_pkg::LATCH_RESET;
        end
        else
        begin
            port_zero_latch_q <= latch_next(port_zero_latch_q,
                                            port_pkg::PORT0_ADDR);
            port_one_latch_q  <= latch_next(port_one_latch_q,
                                            port_pkg::PORT1_ADDR);
            port_two_latch_q  <= latch_next(port_two_latch_q,
                                            port_pkg::PORT2_ADDR);
        end
    end

    // reserved bits are stored as written; software keeps them clear
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            port_one_pullup_disable_q <= port_pkg::PULL_RESET;
            port_two_pullup_disable_q <= port_pkg::PULL_RESET;
        end
        else
        begin
            if (sfr_wr && sfr_addr == port_pkg::PULL1_ADDR)
                port_one_pullup_disable_q <= sfr_wdata;
            if (sfr_wr && sfr_addr == port_pkg::PULL2_ADDR)
                port_two_pullup_disable_q <= sfr_wdata;
        end
    end

    assign p0if.latch    = port_zero_latch_q;
    assign p0if.pull_dis = '0;
    assign p0if.alt_en   = port_zero_alt_en;
    assign p0if.alt_out  = port_zero_alt_out;
    assign p1if.latch    = port_one_latch_q;
    assign p1if.pull_dis = port_one_pullup_disable_q;
    assign p1if.alt_en   = port_one_alt_en;
    assign p1if.alt_out  = port_one_alt_out;
    assign p2if.latch    = port_two_latch_q[2:0];
    assign p2if.pull_dis = port_two_pullup_disable_q[2:0];
    assign p2if.alt_en   = port_two_alt_en;
    assign p2if.alt_out  = port_two_alt_out;

    assign serial_download_pin = port_two_latch_q[port_pkg::SDL_BIT];
    assign reset_pin_pullup_en =
        ~port_two_pullup_disable_q[port_pkg::RST_PULL_BIT];

    pad_drive #(.N(8)) u_p0 (
        .core_clk      (core_clk),
        .rstn          (rstn),
        .ctl           (p0if.pad),
        .pin_in        (port_zero_pin_in),
        .pin_out       (port_zero_pin_out),
        .pin_oe_n      (port_zero_oe_n),
        .pin_pullup_en (port_zero_pullup_en)
    );
    pad_drive #(.N(8)) u_p1 (
        .core_clk      (core_clk),
        .rstn          (rstn),
        .ctl           (p1if.pad),
        .pin_in        (port_one_pin_in),
        .pin_out       (port_one_pin_out),
        .pin_oe_n      (port_one_oe_n),
        .pin_pullup_en (port_one_pullup_en)
    );
    pad_drive #(.N(port_pkg::P2_PINS)) u_p2 (
        .core_clk      (core_clk),
        .rstn          (rstn),
        .ctl           (p2if.pad),
        .pin_in        (port_two_pin_in),
        .pin_out       (port_two_pin_out),
        .pin_oe_n      (port_two_oe_n),
        .pin_pullup_en (port_two_pullup_en)
    );

    // download bit cannot be seen from either path, so it reads one
    assign p0_view = read_pin_sel ? p0if.level : port_zero_latch_q;
    assign p1_view = read_pin_sel ? p1if.level : port_one_latch_q;
    assign p2_view = {port_two_latch_q[7:4], 1'b1,
                      read_pin_sel ? p2if.level
                                   : port_two_latch_q[2:0]};

    always_comb
    begin
        if (sfr_addr == port_pkg::PORT0_ADDR)
            rd_d = p0_view;
        else if (sfr_addr == port_pkg::PORT1_ADDR)
            rd_d = p1_view;
        else if (sfr_addr == port_pkg::PORT2_ADDR)
            rd_d = p2_view;
        else if (sfr_addr == port_pkg::PULL1_ADDR)
            rd_d = port_one_pullup_disable_q;
        else if (sfr_addr == port_pkg::PULL2_ADDR)
            rd_d = port_two_pullup_disable_q;
        else
            rd_d = port_pkg::UNMAPPED_RD;
    end

    always_comb
    begin
        if (bit_sel(port_pkg::PORT0_ADDR, bit_addr))
            bit_d = p0_view[bit_addr[2:0]];
        else if (bit_sel(port_pkg::PORT1_ADDR, bit_addr))
            bit_d = p1_view[bit_addr[2:0]];
        else if (bit_sel(port_pkg::PORT2_ADDR, bit_addr))
            bit_d = p2_view[bit_addr[2:0]];
        else
            bit_d = 1'b0;
    end

    assign sfr_hit = sfr_addr == port_pkg::PORT0_ADDR
                  || sfr_addr == port_pkg::PORT1_ADDR
                  || sfr_addr == port_pkg::PORT2_ADDR
                  || sfr_addr == port_pkg::PULL1_ADDR
                  || sfr_addr == port_pkg::PULL2_ADDR;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sfr_rdata <= 8'h00;
            bit_rdata <= 1'b0;
        end
        else
        begin
            if (sfr_rd)
                sfr_rdata <= rd_d;
            if (bit_rd)
                bit_rdata <= bit_d;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence pull1_write_s;
        sfr_wr && sfr_addr == port_pkg::PULL1_ADDR;
    endsequence
    sequence pull1_quiet_s;
        !(sfr_wr && sfr_addr == port_pkg::PULL1_ADDR);
    endsequence

    p0_byte_write_a: assert property (
        sfr_wr && sfr_addr == port_pkg::PORT0_ADDR
        |=> port_zero_latch_q == $past(sfr_wdata))
        else $error("port zero byte write not stored");

    p1_bit_write_a: assert property (
        bit_wr && !sfr_wr && bit_sel(port_pkg::PORT1_ADDR, bit_addr)
        |=> port_one_latch_q[$past(bit_addr[2:0])] == $past(bit_wdata))
        else $error("port one bit write not stored");

    bit_keep_a: assert property (
        bit_wr && !sfr_wr && bit_sel(port_pkg::PORT1_ADDR, bit_addr)
        |=> ((port_one_latch_q ^ $past(port_one_latch_q))
             & ~(8'h01 << $past(bit_addr[2:0]))) == 8'h00)
        else $error("bit write disturbed other bits");

    pull1_pin_a: assert property (
        pull1_write_s ##1 pull1_quiet_s
        |=> port_one_pullup_en == ~$past(sfr_wdata, 2))
        else $error("port one pull-up not following register");

    rst_pullup_a: assert property (
        sfr_wr && sfr_addr == port_pkg::PULL2_ADDR
        |=> reset_pin_pullup_en == !$past(sfr_wdata[5]))
        else $error("reset pin pull-up wrong");

    download_pin_a: assert property (
        bit_wr && !sfr_wr && bit_addr == {port_pkg::PORT2_ADDR[7:3], 3'h3}
        |=> serial_download_pin == $past(bit_wdata))
        else $error("download pin not driven from latch");

    p2_pin_read_a: assert property (
        sfr_rd && sfr_addr == port_pkg::PORT2_ADDR && read_pin_sel
        |=> sfr_rdata[3] && sfr_rdata[2:0] == $past(p2if.level))
        else $error("port two pin read wrong");

    p1_latch_read_a: assert property (
        sfr_rd && sfr_addr == port_pkg::PORT1_ADDR && !read_pin_sel
        |=> sfr_rdata == $past(port_one_latch_q))
        else $error("latch read path wrong");

    latch_low_a: assert property (
        !port_zero_latch_q[0] |=> !port_zero_oe_n[0])
        else $error("pin not driven low with latch zero");

    // pads are still held in reset on the release edge itself
    alt_pass_a: assert property (
        rstn && port_one_latch_q[1] && port_one_alt_en[1]
        |=> port_one_oe_n[1] == $past(port_one_alt_out[1]))
        else $error("alternate function not passed");
endmodule

// ==== bench/pin_partner.sv ====
// outside world of one port: wired-and pads, drivers, pull-ups
`timescale 1ns/1ps
module pin_partner #(parameter int N = 8)
(
    input  wire logic         core_clk,
    input  wire logic [N-1:0] oe_n,
    input  wire logic [N-1:0] pullup_en,
    input  wire logic [N-1:0] ext_en,
    input  wire logic [N-1:0] ext_val,
    output logic      [N-1:0] level
);
    logic [N-1:0] wobble_q = '0;

    // a floating pad must not keep showing its last level
    always @(posedge core_clk)
        wobble_q <= ~wobble_q;

    // a sinking chip pad wins over any outside driver
    always_comb
        for (int i = 0; i < N; i++)
            level[i] = !oe_n[i] ? 1'b0 : ext_en[i] ? ext_val[i] :
                       pullup_en[i] ? 1'b1 : wobble_q[i];
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the port latch and pull-up block
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module tb_top;
    logic       core_clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
    logic       sfr_wr = 1'b0, sfr_rd = 1'b0, read_pin_sel = 1'b0;
    logic       bit_wdata = 1'b0, bit_wr = 1'b0, bit_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic       sfr_hit, bit_rdata, sdl, rpu;
    logic [7:0] z_in, z_out, z_oen, z_pu, o_in, o_out, o_oen, o_pu;
    logic [2:0] t_in, t_out, t_oen, t_pu;
    logic [7:0] z_aen = 8'h00, z_aout = 8'h00, z_xen = 8'h00, z_xv = 8'h00;
    logic [7:0] o_aen = 8'h00, o_aout = 8'h00, o_xen = 8'h00, o_xv = 8'h00;
    logic [2:0] t_aen = 3'h0, t_aout = 3'h0, t_xen = 3'h0, t_xv = 3'h0;
    int         bad_count = 0, n_checks = 0, seed = 32'h82e3, p, b;
    logic [8:0] exp_q[$];
    logic [8:0] note;
    logic       pend_byte = 1'b0, pend_bit = 1'b0;
    logic [7:0] lat [3] = '{8'hff, 8'hff, 8'hff};
    logic [7:0] base [3] = '{8'h80, 8'h90, 8'ha0};
    logic [7:0] pv [3] = '{8'h20, 8'h05, 8'h27};
    logic [7:0] r, pu1 = 8'h00, pu2 = 8'h00;
    logic [23:0] w;

    always #2.5 core_clk = ~core_clk;

    port_latches_and_pullup_control uut
    (
        .core_clk, .rstn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
        .read_pin_sel, .sfr_rdata, .sfr_hit, .bit_addr, .bit_wdata,
        .bit_wr, .bit_rd, .bit_rdata,
        .port_zero_pin_in(z_in), .port_zero_pin_out(z_out),
        .port_zero_oe_n(z_oen), .port_zero_pullup_en(z_pu),
        .port_zero_alt_en(z_aen), .port_zero_alt_out(z_aout),
        .port_one_pin_in(o_in), .port_one_pin_out(o_out),
        .port_one_oe_n(o_oen), .port_one_pullup_en(o_pu),
        .port_one_alt_en(o_aen), .port_one_alt_out(o_aout),
        .port_two_pin_in(t_in), .port_two_pin_out(t_out),
        .port_two_oe_n(t_oen), .port_two_pullup_en(t_pu),
        .port_two_alt_en(t_aen), .port_two_alt_out(t_aout),
        .serial_download_pin(sdl), .reset_pin_pullup_en(rpu)
    );
    pin_partner #(.N(8)) pz (.core_clk, .oe_n(z_oen), .pullup_en(z_pu),
        .ext_en(z_xen), .ext_val(z_xv), .level(z_in));
    pin_partner #(.N(8)) po (.core_clk, .oe_n(o_oen), .pullup_en(o_pu),
        .ext_en(o_xen), .ext_val(o_xv), .level(o_in));
    pin_partner #(.N(3)) pt (.core_clk, .oe_n(t_oen), .pullup_en(t_pu),
        .ext_en(t_xen), .ext_val(t_xv), .level(t_in));

    // read data lands one edge after the strobe is taken
    always @(posedge core_clk)
    begin
        pend_byte <= sfr_rd;
        pend_bit <= bit_rd;
    end
    always @(negedge core_clk)
    begin
        if ((pend_byte || pend_bit) && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            if (note[8]) `CHK("bit_rdata", note[0], bit_rdata)
            else `CHK("sfr_rdata", note[7:0], sfr_rdata)
        end
    end

    // kind 0 byte write, 1 byte read, 2 bit write, 3 bit read
    task automatic op(input int k, input logic [7:0] a, input logic [7:0] d,
                      input logic ps = 1'b0);
        @(posedge core_clk);
        read_pin_sel <= ps;
        sfr_addr <= a;
        bit_addr <= a;
        sfr_wdata <= d;
        bit_wdata <= d[0];
        sfr_wr <= (k == 0);
        sfr_rd <= (k == 1);
        bit_wr <= (k == 2);
        bit_rd <= (k == 3);
        if (k == 1 || k == 3)
            exp_q.push_back({k == 3, d});
        @(posedge core_clk);
        {sfr_wr, sfr_rd, bit_wr, bit_rd} <= 4'h0;
    endtask

    function automatic logic [7:0] want(input logic [7:0] l, en, ao);
        return l & (~en | ao);
    endfunction

    // pads settle two edges after a write, plus slack
    task automatic pins;
        repeat (4) @(posedge core_clk);
        w = {want(lat[0], z_aen, z_aout), want(lat[1], o_aen, o_aout),
             want(lat[2], {5'h0, t_aen}, {5'h0, t_aout})};
        `CHK("oe_n", {w[23:8], w[2:0]}, {z_oen, o_oen, t_oen})
        `CHK("pin_out", {w[23:8], w[2:0]}, {z_out, o_out, t_out})
        `CHK("download", lat[2][3], sdl)
        `CHK("pull", {8'hff, ~pu1, ~pu2[2:0], ~pu2[5]},
             {z_pu, o_pu, t_pu, rpu})
    endtask

    // port 2 bit 3 has no readable pad and reads as one
    task automatic regs(input logic ps);
        for (int i = 0; i < 3; i++)
            op(1, base[i], i == 2 ? lat[i] | 8'h08 : lat[i], ps);
        op(1, 8'hb3, pu1);
        op(1, 8'hb4, pu2);
        for (int i = 0; i < 19; i++)
            op(3, base[i / 8] + 8'(i % 8), {7'h0, lat[i / 8][i % 8]},
               ps);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        report_and_stop;
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        pins;
        regs(1'b0);
        regs(1'b1);
        op(1, 8'hb2, 8'h00);
        `CHK("sfr_hit", 1'b0, sfr_hit)
        $display("test reset done");
        for (int k = 0; k < 6; k++)
        begin
            p = k % 3;
            r = 8'($random(seed));
            if (p == 2)
                r[7:4] = 4'hf;
            op(0, base[p], r);
            lat[p] = r;
        end
        pins;
        regs(1'b0);
        regs(1'b1);
        $display("test byte writes done");
        for (int k = 0; k < 24; k++)
        begin
            p = {$random(seed)} % 3;
            b = {$random(seed)} % (p == 2 ? 4 : 8);
            r = 8'($random(seed));
            op(2, base[p] + 8'(b), r);
            lat[p][b] = r[0];
        end
        op(2, 8'ha3, 8'h00);
        lat[2][3] = 1'b0;
        pins;
        regs(1'b1);
        $display("test bit writes done");
        pu1 = 8'($random(seed));
        op(0, 8'hb3, pu1);
        foreach (pv[i])
        begin
            pu2 = pv[i];
            op(0, 8'hb4, pu2);
            pins;
        end
        regs(1'b0);
        r = 8'($random(seed));
        o_xv <= r;
        o_xen <= 8'hff;
        pins;
        op(1, 8'h90, r & lat[1], 1'b1);
        o_xen <= 8'h00;
        $display("test pull-ups done");
        op(0, 8'h90, 8'hff);
        lat[1] = 8'hff;
        op(2, 8'h80, 8'h00);
        lat[0][0] = 1'b0;
        z_aen <= 8'($random(seed));
        z_aout <= 8'($random(seed));
        o_aen <= 8'($random(seed)) | 8'h02;
        o_aout <= 8'($random(seed));
        t_aen <= 3'($random(seed));
        t_aout <= 3'($random(seed));
        pins;
        $display("test alternate done");
        rstn <= 1'b0;
        @(posedge core_clk);
        rstn <= 1'b1;
        lat = '{8'hff, 8'hff, 8'hff};
        pu1 = 8'h00;
        pu2 = 8'h00;
        pins;
        regs(1'b0);
        $display("test second reset done");
        repeat (3) @(posedge core_clk);
        `CHK("queue", 0, exp_q.size())
        report_and_stop;
    end
endmodule
